// ===== core/adc_conversion_host_interface.sv
`timescale 1ns/100ps
// Notes on behaviour
// - Trigger held high selects read-start mode; select and read start conversion.
// - Timed mode: trigger falling edge starts conversion, puts sample-hold in hold.
// - Busy low throughout conversion; rises at end; tracking resumes then.
// - Read drives result; interrupt cleared on rising select or read.
// - Read-start mode: busy falls after select and read go low.
// - Read-start mode samples input on read falling edge with select low.
// - Busy rise presents the new result; host completes the read.
// - During read-started conversion the previous result is on the bus.
// - Conversion lasts eight conversion clocks; result moves to output latch.
// - Interrupt driven low at the end of each conversion.
// - Conversion clock ignored once conversion completes.
module adc_conversion_host_interface
  import adc_ctl_pkg::*;
#(
  parameter int unsigned CONV_LEN = CONV_CYCLES
) (
  // Clock, reset, enable
  input  wire logic              core_clk_in,
  input  wire logic              srst_in,
  input  wire logic              clk_en_in,
  // Host bus
  input  wire logic              chip_select_n_in,
  input  wire logic              read_n_in,
  input  wire logic              conversion_trigger_n_in,
  output logic [DATA_W-1:0]      data_out,
  output logic [DATA_W-1:0]      data_oe_n_out,
  output logic                   busy_n_out,
  output logic                   int_n_out,
  // Converter core
  input  wire logic              conv_clk_in,
  input  wire logic              comparator_in,
  output logic                   hold_out,
  output logic [DATA_W-1:0]      dac_code_out
);

  // ****************************************
  // Edge detection of host strobes and conversion clock
  // ****************************************
  logic        cs_n_q;
  logic        rd_n_q;
  logic        trig_n_q;
  logic        cclk_q;
  logic        access;
  logic        access_fall;
  logic        access_rise;
  logic        trig_fall;
  logic        cclk_rise;
  logic        read_mode;
  conv_state_t state_r;
  logic [CNT_W-1:0]  bit_cnt_r;
  logic [DATA_W-1:0] approximation_register_r;
  logic [DATA_W-1:0] result_r;
  logic [DATA_W-1:0] trial;
  logic              start;

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      cs_n_q   <= 1'b1;
      rd_n_q   <= 1'b1;
      trig_n_q <= 1'b1;
      cclk_q   <= 1'b0;
    end else if (clk_en_in) begin
      cs_n_q   <= chip_select_n_in;
      rd_n_q   <= read_n_in;
      trig_n_q <= conversion_trigger_n_in;
      cclk_q   <= conv_clk_in;
    end
  end

  assign access      = !chip_select_n_in && !read_n_in;
  assign access_fall = access && (cs_n_q || rd_n_q);
  assign access_rise = !(cs_n_q || rd_n_q) && !access;
  assign trig_fall   = trig_n_q && !conversion_trigger_n_in;
  assign cclk_rise   = !cclk_q && conv_clk_in;
  // Trigger high at access start means read-start mode
  assign read_mode   = conversion_trigger_n_in && trig_n_q;
  assign start       = (state_r == IDLE) &&
                       ((access_fall && read_mode) ||
                        trig_fall);

  // ****************************************
  // Conversion sequencer
  // ****************************************
  assign trial = approximation_register_r |
                 (DATA_W'(1) << (DATA_W - 1 - bit_cnt_r[2:0]));

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      state_r                  <= IDLE;
      bit_cnt_r                <= CNT_RST;
      approximation_register_r <= RESULT_RST;
      result_r                 <= RESULT_RST;
    end else if (clk_en_in) begin
      case (state_r)
        IDLE: begin
          if (start) begin
            state_r   <= CONVERT;
            bit_cnt_r <= CNT_RST;
          end
        end
        CONVERT: begin
          if (cclk_rise) begin
            approximation_register_r <= comparator_in ? trial :
              (trial & ~(DATA_W'(1) << (DATA_W - 1 - bit_cnt_r[2:0])));
            bit_cnt_r <= bit_cnt_r + CNT_W'(1);
            if (bit_cnt_r == CNT_W'(CONV_LEN - 1)) begin
              state_r <= LATCH;
            end
          end
        end
        LATCH: begin
          // Latch result, clear register; clock now ignored
          result_r                 <= approximation_register_r;
          approximation_register_r <= RESULT_RST;
          state_r                  <= IDLE;
        end
        default: state_r <= IDLE;
      endcase
    end
  end

  // ****************************************
  // Status outputs and interrupt
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      int_n_out <= 1'b1;
    end else if (clk_en_in) begin
      if (state_r == LATCH) begin
        int_n_out <= 1'b0;
      end else if (access_rise) begin
        int_n_out <= 1'b1;
      end
    end
  end

  assign busy_n_out   = (state_r == IDLE);
  assign hold_out     = (state_r != IDLE);
  assign dac_code_out = trial;

  // ****************************************
  // Data bus
  // ****************************************
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      data_out <= RESULT_RST;
    end else if (clk_en_in) begin
      // Old result while busy, new one after latch
      data_out <= (state_r == LATCH) ? approximation_register_r
                                       : result_r;
    end
  end

  assign data_oe_n_out = {DATA_W{!access}};

  // ****************************************
  // Checks
  // ****************************************
  // Conversion clock rises seen in this conversion
  logic [CNT_W-1:0] rise_seen_r;

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      rise_seen_r <= CNT_RST;
    end else if (clk_en_in) begin
      if (state_r == IDLE) begin
        rise_seen_r <= CNT_RST;
      end else if (state_r == CONVERT && cclk_rise) begin
        rise_seen_r <= rise_seen_r + CNT_W'(1);
      end
    end
  end

  sequence s_conv_end;
    clk_en_in && state_r == LATCH ##1 busy_n_out;
  endsequence

  a_bus_release: assert property (@(posedge core_clk_in) disable iff (srst_in)
    !access |-> (&data_oe_n_out))
    else $error("data bus driven outside read");
  a_trig_start: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (clk_en_in && state_r == IDLE && trig_fall)
      |=> !busy_n_out && hold_out)
    else $error("trigger did not start conversion");
  a_read_start: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (clk_en_in && state_r == IDLE && access_fall && read_mode)
      |=> !busy_n_out)
    else $error("read did not start conversion");
  a_busy_hold: assert property (@(posedge core_clk_in) disable iff (srst_in)
    $rose(busy_n_out) |-> !hold_out && $past(state_r) == LATCH)
    else $error("busy rose without a finished conversion");
  a_int_end: assert property (@(posedge core_clk_in) disable iff (srst_in)
    s_conv_end |-> !int_n_out)
    else $error("interrupt not set at end");
  a_int_clear: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (clk_en_in && access_rise && state_r != LATCH) |=> int_n_out)
    else $error("interrupt not cleared");
  a_old_data: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (clk_en_in && state_r == CONVERT)
      |=> data_out == $past(result_r))
    else $error("old result not presented");
  a_new_data: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (clk_en_in && state_r == LATCH)
      |=> data_out == $past(approximation_register_r))
    else $error("new result not presented");
  a_conv_len: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (clk_en_in && state_r == CONVERT && cclk_rise &&
     bit_cnt_r == CNT_W'(CONV_LEN - 1))
      |=> state_r == LATCH)
    else $error("conversion length wrong");
  a_conv_clocks: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (state_r == LATCH) |-> rise_seen_r == CNT_W'(CONV_LEN))
    else $error("conversion clock count wrong");
  a_clk_ignored: assert property (@(posedge core_clk_in) disable iff (srst_in)
    (state_r == IDLE) |=> $stable(approximation_register_r))
    else $error("register moved while idle");

endmodule

// ===== core/adc_ctl_pkg.sv
package adc_ctl_pkg;
  // ****************************************
  // Sizes and counts
  // ****************************************
  localparam int unsigned DATA_W       = 8;
  localparam int unsigned CONV_CYCLES  = 8;
  localparam int unsigned CNT_W        = 4;
  localparam logic [7:0]  RESULT_RST   = 8'h00;
  localparam logic [3:0]  CNT_RST      = 4'h0;

  // ****************************************
  // Conversion states
  // ****************************************
  typedef enum logic [1:0] {
    IDLE    = 2'b00,
    CONVERT = 2'b01,
    LATCH   = 2'b11
  } conv_state_t;
endpackage

// ===== test/adc_conversion_host_interface_tb.sv
`timescale 1ns/100ps
module adc_conversion_host_interface_tb;
  import adc_ctl_pkg::*;
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin \
  err_total++; $display("mismatch %s exp %h got %h", n, e, g); end end
  // ********
  // Stimulus and wiring
  // ********
  logic              core_clk_in = 1'b0;
  logic              srst_in = 1'b1;
  logic              ce = 1'b1;
  logic              cs_n = 1'b1;
  logic              rd_n = 1'b1;
  logic              trig_n = 1'b1;
  logic [DATA_W-1:0] level = 8'h00;
  logic [DATA_W-1:0] prev;
  logic [DATA_W-1:0] d;
  logic [DATA_W-1:0] oe_n;
  logic [DATA_W-1:0] code;
  logic              busy_n;
  logic              int_n;
  logic              hold;
  logic              cclk;
  logic              cmp;
  int                err_total = 0;
  int                checked = 0;
  int                i;

  adc_conversion_host_interface dut (.core_clk_in(core_clk_in),
    .srst_in(srst_in), .clk_en_in(ce), .chip_select_n_in(cs_n),
    .read_n_in(rd_n), .conversion_trigger_n_in(trig_n), .data_out(d),
    .data_oe_n_out(oe_n), .busy_n_out(busy_n), .int_n_out(int_n),
    .conv_clk_in(cclk), .comparator_in(cmp), .hold_out(hold),
    .dac_code_out(code));
  conv_core_model far (.clk_in(core_clk_in), .hold_in(hold),
    .code_in(code), .level_in(level), .conv_clk_out(cclk),
    .comparator_out(cmp));

  initial forever #2 core_clk_in = ~core_clk_in;

  function automatic logic [7:0] sar_model(input logic [7:0] lv);
    logic [7:0] c;
    c = 8'h00;
    for (int b = 7; b >= 0; b--)
      if ((c | (8'h01 << b)) <= lv) c = c | (8'h01 << b);
    return c;
  endfunction

  task automatic wait_busy(input logic lvl);
    int n;
    n = 0;
    while (busy_n !== lvl && n < 60) begin
      @(negedge core_clk_in);
      n++;
    end
    `CHK("busy", lvl, busy_n)
  endtask

  task automatic set_bus(input logic v);
    @(posedge core_clk_in);
    cs_n <= v;
    rd_n <= v;
  endtask

  task automatic results;
    $display("checked %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial begin
    #80000;
    err_total++;
    results;
  end

  initial begin
    void'($urandom(32'h21dd921f));
    repeat (5) @(posedge core_clk_in);
    srst_in <= 1'b0;
    // Timed-start mode, corner levels first
    for (i = 0; i < 8; i++) begin
      @(posedge core_clk_in);
      level <= (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      trig_n <= 1'b0;
      wait_busy(1'b0);
      `CHK("hold", 1'b1, hold)
      wait_busy(1'b1);
      @(negedge core_clk_in);
      `CHK("int", 1'b0, int_n)
      `CHK("track", 1'b0, hold)
      `CHK("idle_oe", 8'hFF, oe_n)
      set_bus(1'b0);
      @(negedge core_clk_in);
      `CHK("oe", 8'h00, oe_n)
      `CHK("data", sar_model(level), d)
      set_bus(1'b1);
      repeat (2) @(negedge core_clk_in);
      `CHK("int_clr", 1'b1, int_n)
      @(posedge core_clk_in);
      trig_n <= 1'b1;
    end
    // Reset in mid-conversion
    @(posedge core_clk_in);
    trig_n <= 1'b0;
    wait_busy(1'b0);
    @(posedge core_clk_in);
    srst_in <= 1'b1;
    trig_n <= 1'b1;
    repeat (2) @(posedge core_clk_in);
    srst_in <= 1'b0;
    @(negedge core_clk_in);
    `CHK("rst_busy", 1'b1, busy_n)
    `CHK("rst_hold", 1'b0, hold)
    `CHK("rst_int", 1'b1, int_n)
    `CHK("rst_data", RESULT_RST, d)
    prev = RESULT_RST;
    // Read-start mode, trigger held high; one conversion frozen
    for (i = 0; i < 4; i++) begin
      @(posedge core_clk_in);
      level <= 8'($urandom);
      set_bus(1'b0);
      wait_busy(1'b0);
      `CHK("old", prev, d)
      if (i == 1) begin
        @(posedge core_clk_in);
        ce <= 1'b0;
        repeat (20) @(negedge core_clk_in);
        `CHK("freeze", 1'b0, busy_n)
        @(posedge core_clk_in);
        ce <= 1'b1;
      end
      wait_busy(1'b1);
      @(negedge core_clk_in);
      `CHK("new", sar_model(level), d)
      `CHK("rs_oe", 8'h00, oe_n)
      `CHK("rs_int", 1'b0, int_n)
      prev = sar_model(level);
      set_bus(1'b1);
      repeat (2) @(negedge core_clk_in);
      `CHK("rs_int_clr", 1'b1, int_n)
    end
    results;
  end
endmodule

// ===== test/conv_core_model.sv
`timescale 1ns/100ps
// ********
// Comparator and gated conversion clock
// ********
module conv_core_model (
  // Core side
  input  wire logic       clk_in,
  input  wire logic       hold_in,
  input  wire logic [7:0] code_in,
  input  wire logic [7:0] level_in,
  // Converter side
  output logic            conv_clk_out,
  output logic            comparator_out
);
  initial conv_clk_out = 1'b0;
  // Runs only while held; stands still low otherwise
  always @(posedge clk_in) conv_clk_out <= hold_in & ~conv_clk_out;
  assign comparator_out = (code_in <= level_in);
endmodule
